// ==== hdl/pin_if_pkg.sv ====
package pin_if_pkg;

  // Pin indices on the connector
  localparam int NUM_FUNC_PINS = 10;
  localparam int PIN_ACQ_START = 0;
  localparam int PIN_ACQ_STOP = 1;
  localparam int PIN_CONVERT = 2;
  localparam int PIN_B_SOURCE = 3;
  localparam int PIN_B_GATE = 4;
  localparam int PIN_UPDATE = 5;
  localparam int PIN_WAVE_START = 6;
  localparam int PIN_SCAN_BEGIN = 7;
  localparam int PIN_A_SOURCE = 8;
  localparam int PIN_A_GATE = 9;

  // Digital lines that steer counter direction
  localparam int DIR_LINE_A = 6;
  localparam int DIR_LINE_B = 7;

  // Reset values
  localparam logic [9:0] PIN_OE_RESET = 10'h000;
  localparam logic STROBE_RESET_N = 1'h1;

  // Width of a pulse on a pulse-shaped output, in cycles
  localparam int PULSE_NS = 50;
  localparam int CLK_NS = 10;
  localparam int PULSE_CYCLES = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] PULSE_LAST = 4'(PULSE_CYCLES - 1);

  // Acquisition sequencing states (Gray coded from idle through pre to post)
  typedef enum logic [1:0] {
    ACQ_IDLE = 2'h0,
    ACQ_PRE = 2'h1,
    ACQ_POST = 2'h3
  } acq_state_t;

  // Internal timing events from the acquisition and output engines
  typedef struct packed {
    logic acq_start;
    logic acq_stop;
    logic convert;
    logic scan_begin;
    logic update;
    logic wave_start;
  } timing_events_t;

  // Counter signals as selected inside the board
  typedef struct packed {
    logic a_source;
    logic a_gate;
    logic a_output;
    logic b_source;
    logic b_gate;
    logic b_output;
  } counter_sigs_t;

endpackage

// ==== hdl/pulse_stretch.sv ====
`timescale 1ns/1ps
// Turns a one-cycle event into a fixed-width high pulse
module pulse_stretch
  import pin_if_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic event_in,
  output logic pulse_out
);
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic busy_q;
  logic busy_d;
  wire logic at_end = (cnt_q == PULSE_LAST);

  // A new event during a pulse restarts it, so back-to-back events merge
  assign busy_d = event_in | (busy_q & ~at_end);
  assign cnt_d = event_in ? 4'h0 : (busy_q ? cnt_q + 4'h1 : cnt_q);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      busy_q <= 1'b0;
      cnt_q <= 4'h0;
    end else begin
      busy_q <= busy_d;
      cnt_q <= cnt_d;
    end
  end

  assign pulse_out = busy_q;
endmodule

// ==== hdl/func_pin_cell.sv ====
`timescale 1ns/1ps
// One programmable function pin: input path always live, driver gated
module func_pin_cell
  import pin_if_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic drive_en_in,
  input wire logic signal_in,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe_out,
  output logic pin_level_out
);
  logic pin_q;
  logic oe_q;
  logic lvl_q;

  // Registered drive keeps the connector free of glitches
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pin_q <= 1'b1;
      oe_q <= 1'b0;
      lvl_q <= 1'b1;
    end else begin
      pin_q <= signal_in;
      oe_q <= drive_en_in;
      lvl_q <= pin_in;
    end
  end

  assign pin_out = pin_q;
  assign pin_oe_out = oe_q;
  assign pin_level_out = lvl_q;
endmodule

// ==== hdl/timing_signal_pin_interface.sv ====
`timescale 1ns/1ps
// Behaviour
// R1: Digital line 6 sets counter A direction; line 7 sets counter B.
// R2: Scan clock, when enabled, pulses once per conversion during scanning.
// R3: Scan clock rising edge marks when the input may be switched.
// R4: Software strobe changes level only on software command.
// R5: Each function pin is a selectable input or drives its own timing signal.
// R6: Post-trigger: rising edge on pin 0 start trigger begins acquisition.
// R7: Pre-trigger: rising edge on start trigger begins pre-trigger conversions.
// R8: Pre-trigger: rising edge on pin 1 stop trigger begins post-trigger conversions.
// R9: Stop trigger unused and not generated in post-trigger mode.
// R10: Active-low convert strobe on pin 2 falls at each conversion.
// R11: Pins 3 and 4 reproduce counter B selected source and gate.
// R12: Pins 8 and 9 reproduce counter A selected source and gate.
// R13: Dedicated pins carry counter B and counter A outputs.
// R14: Active-low update strobe on pin 5 falls at each output update.
// R15: Rising edge on pin 6 waveform trigger starts waveform generation.
// R16: Pin 7 scan begin pulses once per scan, rising edge at start.
// R17: A dedicated pin outputs the rate generator signal.
// R18: Asterisk signals are active low wherever driven or sampled.
// R19: Each function pin driver is enabled individually by software.
// R20: Several timing signals may take the same pin as input at once.
// R21: After reset all function pin drivers are off.
module timing_signal_pin_interface
  import pin_if_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire timing_events_t events_in,
  input wire counter_sigs_t counters_in,
  input wire logic rate_generator_in,
  input wire logic pretrigger_mode_in,
  input wire logic scanning_in,
  input wire logic scan_clock_en_in,
  input wire logic [9:0] pin_drive_en_in,
  input wire logic strobe_write_in,
  input wire logic strobe_level_in,
  input wire logic [3:0] sel_a_in,
  input wire logic [3:0] sel_b_in,
  input wire logic [3:0] sel_c_in,
  input wire logic [9:0] programmable_function_pin_in,
  output logic [9:0] programmable_function_pin_out,
  output logic [9:0] programmable_function_pin_oe_out,
  output logic [9:0] pin_level_out,
  output logic ext_sel_a_out,
  output logic ext_sel_b_out,
  output logic ext_sel_c_out,
  input wire logic [7:0] general_digital_lines_in,
  output logic counter_a_up_out,
  output logic counter_b_up_out,
  output logic conversion_pulse_out,
  output logic software_strobe_n_out,
  output logic counter_a_output_out,
  output logic counter_b_output_out,
  output logic rate_generator_output_out,
  output acq_state_t acq_state_out
);

  // Selects one of the sampled pin levels; an index past the top reads low
  function automatic logic pick_pin(input logic [9:0] lv, input logic [3:0] idx);
    pick_pin = (idx < 4'hA) ? lv[idx] : 1'b0;
  endfunction

  logic [9:0] drive_en_q;
  logic strobe_n_q;
  logic scan_clk_q;
  logic ctr_a_q;
  logic ctr_b_q;
  logic rate_q;
  logic dir_a_q;
  logic dir_b_q;
  logic sel_a_q;
  logic sel_b_q;
  logic sel_c_q;
  acq_state_t acq_q;
  acq_state_t acq_d;
  logic [9:0] sig_drive;
  logic [9:0] level_w;
  logic start_pulse;
  logic stop_pulse;
  logic scan_pulse;
  logic wave_pulse;
  logic convert_pulse;
  logic update_pulse;
  logic scan_clk_pulse;

  // Fixed-width high pulses for the trigger style outputs
  pulse_stretch u_start (.clk_in(clk_in), .rst_in(rst_in),
    .event_in(events_in.acq_start), .pulse_out(start_pulse));
  pulse_stretch u_stop (.clk_in(clk_in), .rst_in(rst_in),
    .event_in(events_in.acq_stop && acq_q == ACQ_PRE), .pulse_out(stop_pulse)); // [R9]
  pulse_stretch u_scan (.clk_in(clk_in), .rst_in(rst_in),
    .event_in(events_in.scan_begin), .pulse_out(scan_pulse));
  pulse_stretch u_wave (.clk_in(clk_in), .rst_in(rst_in),
    .event_in(events_in.wave_start), .pulse_out(wave_pulse));
  pulse_stretch u_conv (.clk_in(clk_in), .rst_in(rst_in),
    .event_in(events_in.convert), .pulse_out(convert_pulse));
  pulse_stretch u_upd (.clk_in(clk_in), .rst_in(rst_in),
    .event_in(events_in.update), .pulse_out(update_pulse));
  pulse_stretch u_sclk (.clk_in(clk_in), .rst_in(rst_in),
    .event_in(events_in.convert & scanning_in & scan_clock_en_in), // [R2]
    .pulse_out(scan_clk_pulse));

  // Each pin has exactly one internal signal it may drive
  assign sig_drive[PIN_ACQ_START] = start_pulse; // [R6] [R7]
  assign sig_drive[PIN_ACQ_STOP] = stop_pulse; // [R8]
  assign sig_drive[PIN_CONVERT] = ~convert_pulse; // [R10] [R18]
  assign sig_drive[PIN_B_SOURCE] = counters_in.b_source; // [R11]
  assign sig_drive[PIN_B_GATE] = counters_in.b_gate; // [R11]
  assign sig_drive[PIN_UPDATE] = ~update_pulse; // [R14] [R18]
  assign sig_drive[PIN_WAVE_START] = wave_pulse; // [R15]
  assign sig_drive[PIN_SCAN_BEGIN] = scan_pulse; // [R16]
  assign sig_drive[PIN_A_SOURCE] = counters_in.a_source; // [R12]
  assign sig_drive[PIN_A_GATE] = counters_in.a_gate; // [R12]

  // Pin cells: input is sampled even while the driver is on
  for (genvar i = 0; i < NUM_FUNC_PINS; i++) begin : g_pin
    func_pin_cell u_cell (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .drive_en_in(drive_en_q[i]), // [R19]
      .signal_in(sig_drive[i]), // [R5]
      .pin_in(programmable_function_pin_in[i]),
      .pin_out(programmable_function_pin_out[i]),
      .pin_oe_out(programmable_function_pin_oe_out[i]),
      .pin_level_out(level_w[i])
    );
  end

  // Acquisition sequence: pre-trigger waits for the stop trigger
  always_comb begin
    acq_d = acq_q;
    unique case (acq_q)
      ACQ_IDLE: begin
        if (events_in.acq_start) begin
          acq_d = pretrigger_mode_in ? ACQ_PRE : ACQ_POST; // [R6] [R7]
        end
      end
      ACQ_PRE: begin
        if (events_in.acq_stop) begin
          acq_d = ACQ_POST; // [R8]
        end
      end
      ACQ_POST: begin
        if (!scanning_in) begin
          acq_d = ACQ_IDLE;
        end
      end
      default: acq_d = ACQ_IDLE;
    endcase
  end

  // Driver enables, strobe and dedicated outputs all registered
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      drive_en_q <= PIN_OE_RESET; // [R21]
      strobe_n_q <= STROBE_RESET_N;
      acq_q <= ACQ_IDLE;
      scan_clk_q <= 1'b0;
      ctr_a_q <= 1'b0;
      ctr_b_q <= 1'b0;
      rate_q <= 1'b0;
      dir_a_q <= 1'b0;
      dir_b_q <= 1'b0;
      sel_a_q <= 1'b0;
      sel_b_q <= 1'b0;
      sel_c_q <= 1'b0;
    end else begin
      drive_en_q <= pin_drive_en_in; // [R19]
      if (strobe_write_in) begin
        strobe_n_q <= strobe_level_in; // [R4]
      end
      acq_q <= acq_d;
      scan_clk_q <= scan_clk_pulse; // [R3]
      ctr_a_q <= counters_in.a_output; // [R13]
      ctr_b_q <= counters_in.b_output; // [R13]
      rate_q <= rate_generator_in; // [R17]
      dir_a_q <= general_digital_lines_in[DIR_LINE_A]; // [R1]
      dir_b_q <= general_digital_lines_in[DIR_LINE_B]; // [R1]
      sel_a_q <= pick_pin(level_w, sel_a_in); // [R20]
      sel_b_q <= pick_pin(level_w, sel_b_in); // [R20]
      sel_c_q <= pick_pin(level_w, sel_c_in); // [R20]
    end
  end

  assign pin_level_out = level_w;
  assign ext_sel_a_out = sel_a_q;
  assign ext_sel_b_out = sel_b_q;
  assign ext_sel_c_out = sel_c_q;
  assign counter_a_up_out = dir_a_q;
  assign counter_b_up_out = dir_b_q;
  assign conversion_pulse_out = scan_clk_q;
  assign software_strobe_n_out = strobe_n_q;
  assign counter_a_output_out = ctr_a_q;
  assign counter_b_output_out = ctr_b_q;
  assign rate_generator_output_out = rate_q;
  assign acq_state_out = acq_q;

  // Checks kept beside the logic
  a_drivers_reset_off: assert property (@(posedge clk_in) // [R21]
    $past(rst_in) |-> programmable_function_pin_oe_out == 10'h000)
    else $error("function pin driver on after reset");
  a_driver_follows_en: assert property (@(posedge clk_in) disable iff (rst_in) // [R19]
    !pin_drive_en_in[PIN_UPDATE] |=> ##1 !programmable_function_pin_oe_out[PIN_UPDATE])
    else $error("update pin driven without enable");
  a_strobe_only_sw: assert property (@(posedge clk_in) disable iff (rst_in) // [R4]
    !strobe_write_in |=> $stable(software_strobe_n_out))
    else $error("strobe moved without software");
  a_scan_clk_pulse: assert property (@(posedge clk_in) disable iff (rst_in) // [R2]
    (events_in.convert && scanning_in && scan_clock_en_in) |-> ##2 conversion_pulse_out)
    else $error("scan clock missed a conversion");
  a_scan_clk_off: assert property (@(posedge clk_in) disable iff (rst_in) // [R2]
    (!scan_clock_en_in)[*8] |-> !conversion_pulse_out)
    else $error("scan clock pulsed while disabled");
  a_convert_falls: assert property (@(posedge clk_in) disable iff (rst_in) // [R10]
    events_in.convert |-> ##2 !programmable_function_pin_out[PIN_CONVERT])
    else $error("convert strobe did not fall");
  a_stop_post_quiet: assert property (@(posedge clk_in) disable iff (rst_in) // [R9]
    (acq_q == ACQ_POST)[*8] |-> !programmable_function_pin_out[PIN_ACQ_STOP])
    else $error("stop trigger in post-trigger mode");
  a_pre_to_post: assert property (@(posedge clk_in) disable iff (rst_in) // [R8]
    (acq_q == ACQ_PRE && events_in.acq_stop) |=> acq_q == ACQ_POST)
    else $error("stop trigger ignored in pre-trigger");
  a_dir_lines: assert property (@(posedge clk_in) disable iff (rst_in) // [R1]
    1'b1 |=> counter_a_up_out == $past(general_digital_lines_in[DIR_LINE_A])
      && counter_b_up_out == $past(general_digital_lines_in[DIR_LINE_B]))
    else $error("counter direction not from digital lines");
  a_counter_outs: assert property (@(posedge clk_in) disable iff (rst_in) // [R13]
    1'b1 |=> counter_b_output_out == $past(counters_in.b_output))
    else $error("counter output not passed");
  c_pretrigger_run: cover property (@(posedge clk_in) disable iff (rst_in)
    acq_q == ACQ_PRE ##[1:50] acq_q == ACQ_POST);
  c_scan_pulse: cover property (@(posedge clk_in) disable iff (rst_in)
    $rose(conversion_pulse_out));
  c_strobe_toggle: cover property (@(posedge clk_in) disable iff (rst_in)
    $fell(software_strobe_n_out));
  c_stop_trigger: cover property (@(posedge clk_in) disable iff (rst_in)
    $rose(programmable_function_pin_out[PIN_ACQ_STOP]));
  c_all_drivers: cover property (@(posedge clk_in) disable iff (rst_in)
    programmable_function_pin_oe_out == 10'h3FF);

  // Trigger style pins move two cycles after the engine event
  a_start_pin_rise: assert property (@(posedge clk_in) disable iff (rst_in) // [R6]
    events_in.acq_start |-> ##2 programmable_function_pin_out[PIN_ACQ_START])
    else $error("start trigger pin did not rise");
  a_post_entry: assert property (@(posedge clk_in) disable iff (rst_in) // [R6]
    (acq_q == ACQ_IDLE && events_in.acq_start && !pretrigger_mode_in) |=> acq_q == ACQ_POST)
    else $error("post-trigger acquisition did not begin");
  a_pre_entry: assert property (@(posedge clk_in) disable iff (rst_in) // [R7]
    (acq_q == ACQ_IDLE && events_in.acq_start && pretrigger_mode_in) |=> acq_q == ACQ_PRE)
    else $error("pre-trigger conversions did not begin");
  a_pre_holds: assert property (@(posedge clk_in) disable iff (rst_in) // [R8]
    (acq_q == ACQ_PRE && !events_in.acq_stop) |=> acq_q == ACQ_PRE)
    else $error("pre-trigger left without stop trigger");
  a_stop_pin_rise: assert property (@(posedge clk_in) disable iff (rst_in) // [R8]
    (acq_q == ACQ_PRE && events_in.acq_stop) |-> ##2 programmable_function_pin_out[PIN_ACQ_STOP])
    else $error("stop trigger pin did not rise");
  a_stop_only_pre: assert property (@(posedge clk_in) disable iff (rst_in) // [R9]
    $rose(programmable_function_pin_out[PIN_ACQ_STOP]) |-> $past(acq_q == ACQ_PRE, 2))
    else $error("stop trigger rose outside pre-trigger");
  a_convert_width: assert property (@(posedge clk_in) disable iff (rst_in) // [R10]
    $fell(programmable_function_pin_out[PIN_CONVERT])
      |-> (!programmable_function_pin_out[PIN_CONVERT])[*5])
    else $error("convert strobe too short");
  a_update_falls: assert property (@(posedge clk_in) disable iff (rst_in) // [R14]
    events_in.update |-> ##2 !programmable_function_pin_out[PIN_UPDATE])
    else $error("update strobe did not fall");
  a_wave_pin_rise: assert property (@(posedge clk_in) disable iff (rst_in) // [R15]
    events_in.wave_start |-> ##2 programmable_function_pin_out[PIN_WAVE_START])
    else $error("waveform trigger pin did not rise");
  a_scan_begin_rise: assert property (@(posedge clk_in) disable iff (rst_in) // [R16]
    events_in.scan_begin |-> ##2 programmable_function_pin_out[PIN_SCAN_BEGIN])
    else $error("scan begin pin did not rise");
  a_scan_begin_width: assert property (@(posedge clk_in) disable iff (rst_in) // [R16]
    $rose(programmable_function_pin_out[PIN_SCAN_BEGIN])
      |-> (programmable_function_pin_out[PIN_SCAN_BEGIN])[*5])
    else $error("scan begin pulse too short");
  a_scan_clk_edge: assert property (@(posedge clk_in) disable iff (rst_in) // [R3]
    $rose(conversion_pulse_out)
      |-> $past(events_in.convert && scanning_in && scan_clock_en_in, 2))
    else $error("scan clock rose without a conversion");

  // Copies are one register late, driver enables two; the sampled reset keeps the release edge out
  a_counter_b_pins: assert property (@(posedge clk_in) disable iff (rst_in) // [R11]
    !rst_in |=> programmable_function_pin_out[PIN_B_SOURCE] == $past(counters_in.b_source)
      && programmable_function_pin_out[PIN_B_GATE] == $past(counters_in.b_gate))
    else $error("counter B pins do not follow source and gate");
  a_counter_a_pins: assert property (@(posedge clk_in) disable iff (rst_in) // [R12]
    !rst_in |=> programmable_function_pin_out[PIN_A_SOURCE] == $past(counters_in.a_source)
      && programmable_function_pin_out[PIN_A_GATE] == $past(counters_in.a_gate))
    else $error("counter A pins do not follow source and gate");
  a_counter_a_out: assert property (@(posedge clk_in) disable iff (rst_in) // [R13]
    !rst_in |=> counter_a_output_out == $past(counters_in.a_output))
    else $error("counter A output not passed");
  a_rate_copy: assert property (@(posedge clk_in) disable iff (rst_in) // [R17]
    !rst_in |=> rate_generator_output_out == $past(rate_generator_in))
    else $error("rate generator output not passed");
  a_driver_on: assert property (@(posedge clk_in) disable iff (rst_in) // [R19]
    !rst_in |=> ##1 programmable_function_pin_oe_out == $past(pin_drive_en_in, 2))
    else $error("pin drivers do not follow their enables");
  a_pin_level_follows: assert property (@(posedge clk_in) disable iff (rst_in) // [R5]
    !rst_in |=> pin_level_out == $past(programmable_function_pin_in))
    else $error("pin input path not sampled");
  a_sel_picks: assert property (@(posedge clk_in) disable iff (rst_in) // [R20]
    (!rst_in && sel_a_in < 4'hA) |=> ext_sel_a_out == $past(pin_level_out[sel_a_in]))
    else $error("selected pin level not passed");
  a_sel_high_idx: assert property (@(posedge clk_in) disable iff (rst_in) // [R20]
    (!rst_in && sel_c_in >= 4'hA) |=> !ext_sel_c_out)
    else $error("index past last pin did not read low");
  a_strobe_write: assert property (@(posedge clk_in) disable iff (rst_in) // [R4]
    strobe_write_in |=> software_strobe_n_out == $past(strobe_level_in))
    else $error("strobe write did not land");
endmodule

// ==== test/connector_equipment.sv ====
`timescale 1ns/1ps
// Equipment on the connector; a pin nobody drives floats high on its pull-up
module connector_equipment (
  input wire logic clk_in,
  input wire logic [9:0] dev_data_in,
  input wire logic [9:0] dev_oe_in,
  input wire logic [9:0] drive_en_in,
  input wire logic [9:0] value_in,
  input wire logic scan_clock_in,
  output logic [9:0] pin_out,
  output logic [3:0] channel_out
);
  logic scan_clock_q = 1'h0;
  logic [3:0] channel_q = 4'h0;
  // The device wins where it drives, so the far side never fights it
  always_comb begin
    for (int i = 0; i < 10; i++) begin
      pin_out[i] = dev_oe_in[i] ? dev_data_in[i] : (drive_en_in[i] ? value_in[i] : 1'h1);
    end
  end
  // Step to the next input on each rising scan clock edge
  always @(posedge clk_in) begin
    scan_clock_q <= scan_clock_in;
    if (scan_clock_in && !scan_clock_q) channel_q <= channel_q + 4'h1;
  end
  assign channel_out = channel_q;
endmodule

// ==== test/test_timing_signal_pin_interface.sv ====
`timescale 1ns/1ps
module test_timing_signal_pin_interface;
  import pin_if_pkg::*;
  typedef struct {int due; int idx; logic val;} note_t;
  logic clk_in, rst_in, rate_in, pre_in, scan_in, sclk_en_in, wr_in, lvl_in;
  timing_events_t events_in;
  counter_sigs_t counters_in;
  logic [9:0] drv_en_in, ext_en, ext_val, pin_in, pin_out, oe_out, lvl_out;
  logic [3:0] sel_a, sel_b, sel_c, channel;
  logic [7:0] gdl_in;
  logic ea, eb, ec, upa, upb, conv, stb_n, ca, cb, rate_out;
  acq_state_t state;
  wire logic [41:0] obs = {state, rate_out, cb, ca, stb_n, conv, upb, upa, ec, eb, ea,
    lvl_out, oe_out, pin_out};
  note_t notes[$];
  int ncyc = 0;
  int mismatches = 0;
  int n_tests = 0;
  logic [31:0] seed = 32'h6A39;
  logic [31:0] r;
  logic [5:0] ev[5] = '{6'h20, 6'h08, 6'h04, 6'h02, 6'h01};
  int pin[5] = '{0, 2, 7, 5, 6};

  timing_signal_pin_interface dut (.clk_in(clk_in), .rst_in(rst_in), .events_in(events_in),
    .counters_in(counters_in), .rate_generator_in(rate_in), .pretrigger_mode_in(pre_in),
    .scanning_in(scan_in), .scan_clock_en_in(sclk_en_in), .pin_drive_en_in(drv_en_in),
    .strobe_write_in(wr_in), .strobe_level_in(lvl_in), .sel_a_in(sel_a), .sel_b_in(sel_b),
    .sel_c_in(sel_c), .programmable_function_pin_in(pin_in),
    .programmable_function_pin_out(pin_out), .programmable_function_pin_oe_out(oe_out),
    .pin_level_out(lvl_out), .ext_sel_a_out(ea), .ext_sel_b_out(eb), .ext_sel_c_out(ec),
    .general_digital_lines_in(gdl_in), .counter_a_up_out(upa), .counter_b_up_out(upb),
    .conversion_pulse_out(conv), .software_strobe_n_out(stb_n), .counter_a_output_out(ca),
    .counter_b_output_out(cb), .rate_generator_output_out(rate_out), .acq_state_out(state));
  connector_equipment far (.clk_in(clk_in), .dev_data_in(pin_out), .dev_oe_in(oe_out),
    .drive_en_in(ext_en), .value_in(ext_val), .scan_clock_in(conv), .pin_out(pin_in),
    .channel_out(channel));

  initial begin
    clk_in = 0;
    forever #5 clk_in = ~clk_in;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Note a result due d cycles after the current edge
  task automatic expect_at(int idx, int d, logic v);
    notes.push_back('{ncyc + 1 + d, idx, v});
  endtask

  task automatic check_bit(note_t n);
    n_tests++;
    if (obs[n.idx] !== n.val) begin
      mismatches++;
      $display("wrong value obs[%0d] expected %b seen %b", n.idx, n.val, obs[n.idx]);
    end
  endtask

  task automatic check_count(logic [3:0] exp);
    n_tests++;
    if (channel !== exp) begin
      mismatches++;
      $display("wrong value channel expected %0d seen %0d", exp, channel);
    end
  endtask

  // Watcher: outputs are settled at the falling edge
  always @(negedge clk_in) begin
    ncyc++;
    for (int i = notes.size() - 1; i >= 0; i--) begin
      if (notes[i].due == ncyc) begin
        check_bit(notes[i]);
        notes.delete(i);
      end
    end
  end

  // A pulse output holds its active level for five cycles, then idles
  task automatic pulse(int idx, logic act);
    expect_at(idx, 2, act);
    expect_at(idx, 6, act);
    expect_at(idx, 7, !act);
  endtask

  task automatic fire(logic [5:0] e);
    @(posedge clk_in);
    events_in <= timing_events_t'(e);
  endtask

  task automatic settle(int n);
    @(posedge clk_in);
    events_in <= '0;
    wr_in <= 1'h0;
    repeat (n) @(posedge clk_in);
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    {rst_in, rate_in, pre_in, scan_in, sclk_en_in, wr_in, lvl_in} = 7'h40;
    {events_in, counters_in, drv_en_in, ext_en, ext_val, gdl_in} = '0;
    {sel_a, sel_b, sel_c} = 12'hFFF;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'h0;
    for (int i = 0; i < 10; i++) expect_at(10 + i, 0, 1'h0);
    expect_at(36, 0, 1'h1);
    // Two inputs share one pin; an index past the last pin reads low
    for (int k = 0; k < 2; k++) begin
      r = xs();
      @(posedge clk_in);
      ext_en <= 10'h3FF;
      ext_val <= r[9:0];
      sel_a <= k ? 4'h9 : 4'h3;
      sel_b <= k ? 4'h9 : 4'h3;
      sel_c <= 4'hC;
      for (int i = 0; i < 10; i++) expect_at(20 + i, 1, r[i]);
      expect_at(30, 2, r[k ? 9 : 3]);
      expect_at(31, 2, r[k ? 9 : 3]);
      expect_at(32, 2, 1'h0);
      settle(3);
    end
    // Enable drivers one at a time; the next one must stay off
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_in);
      drv_en_in <= drv_en_in | (10'h001 << i);
      expect_at(10 + i, 2, 1'h1);
      if (i < 9) expect_at(11 + i, 2, 1'h0);
    end
    {ext_en, scan_in, sclk_en_in} <= 12'h003;
    settle(4);
    for (int j = 0; j < 5; j++) begin
      fire(ev[j]);
      pulse(pin[j], !(pin[j] == 2 || pin[j] == 5));
      if (j == 1) pulse(35, 1'h1);
      settle(10);
    end
    fire(6'h10);
    expect_at(1, 2, 1'h0);
    expect_at(1, 4, 1'h0);
    settle(8);
    scan_in <= 1'h0;
    fire(6'h08);
    expect_at(35, 2, 1'h0);
    settle(10);
    check_count(4'h1);
    {pre_in, scan_in} <= 2'h3;
    settle(4);
    fire(6'h20);
    pulse(0, 1'h1);
    settle(10);
    fire(6'h10);
    pulse(1, 1'h1);
    expect_at(40, 8, 1'h1);
    expect_at(41, 8, 1'h1);
    settle(10);
    // Counter, rate and direction copies, changed every cycle
    for (int k = 0; k < 12; k++) begin
      r = xs();
      @(posedge clk_in);
      counters_in <= counter_sigs_t'(r[5:0]);
      rate_in <= r[6];
      gdl_in <= r[15:8];
      expect_at(8, 1, r[5]);
      expect_at(9, 1, r[4]);
      expect_at(3, 1, r[2]);
      expect_at(4, 1, r[1]);
      expect_at(37, 1, r[3]);
      expect_at(38, 1, r[0]);
      expect_at(39, 1, r[6]);
      expect_at(33, 1, r[14]);
      expect_at(34, 1, r[15]);
    end
    @(posedge clk_in);
    wr_in <= 1'h1;
    lvl_in <= 1'h0;
    expect_at(36, 1, 1'h0);
    settle(1);
    lvl_in <= 1'h1;
    expect_at(36, 6, 1'h0);
    settle(8);
    wr_in <= 1'h1;
    expect_at(36, 1, 1'h1);
    settle(2);
    // Scan clock disabled while scanning: convert still strobes, scan clock stays low
    sclk_en_in <= 1'h0;
    fire(6'h08);
    expect_at(35, 2, 1'h0);
    pulse(2, 1'h0);
    settle(8);
    for (int w = 0; w < 50 && notes.size() > 0; w++) @(posedge clk_in);
    if (notes.size() > 0) mismatches++;
    stop_test();
  end
endmodule
